// ---- logic/cts_pkg.sv ----
package cts_pkg;
  // Sensor array and converter shape.
  localparam int N_SENSE = 14;
  localparam int RES_W = 16;
  localparam int AVG_W = 2;
  localparam int GAIN_W = 2;
  localparam int DIR_COUNT = 8;
  localparam logic [3:0] FIRST_STAGE = 4'h0;
  localparam logic [3:0] LAST_STAGE = 4'hD;
  localparam logic [3:0] STAGE_STEP = 4'h1;
  localparam logic [15:0] BASE_STEP = 16'h0001;

  // Compensation memory.
  localparam int RAM_WORDS = 528;
  localparam int RAM_AW = 10;

  // Power mode field codes; bit 0 set means shutdown.
  localparam logic [1:0] PM_FULL = 2'h0;
  localparam logic [1:0] PM_LOW = 2'h2;
  localparam int PM_SHUTDOWN_BIT = 0;

  // Oversampling ratio selected by the decimation field.
  localparam logic [1:0] DEC_256 = 2'h0;
  localparam logic [1:0] DEC_128 = 2'h1;
  localparam logic [8:0] OSR_256 = 9'h100;
  localparam logic [8:0] OSR_128 = 9'h080;

  // Timing: core clock rate and the low power intervals.
  localparam int CLK_HZ = 200000000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int TOUCH_PERIOD_MS = 36;
  localparam int IDLE_STEP_MS = 200;
  localparam int TOUCH_PERIOD_CYC = TOUCH_PERIOD_MS * CYC_PER_MS;
  localparam int IDLE_STEP_CYC = IDLE_STEP_MS * CYC_PER_MS;
  localparam int TIMER_W = 32;

  // Serial frame: address byte, turnaround byte, result word.
  localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
  localparam logic [4:0] BIT_LOAD = 5'h0F;
  localparam logic [4:0] BIT_DATA_FIRST = 5'h10;

  // Read map of the serial port.
  localparam logic [7:0] RD_RESULT_LAST = 8'h0D;
  localparam logic [7:0] RD_STATUS = 8'h10;
  localparam logic [7:0] RD_ACTIVE = 8'h11;
  localparam logic [7:0] RD_SETUP = 8'h12;

  // Core sequencer states.
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SEL = 5'b00010,
    ST_START = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_CALC = 5'b10000
  } cts_state_t;
endpackage

// ---- logic/cts_comp_ram.sv ----
`timescale 1ns/1ps
// Compensation memory with one synchronous read/write port.
module cts_comp_ram
  import cts_pkg::*;
(
  input wire logic clock,
  input wire logic we,
  input wire logic [cts_pkg::RAM_AW-1:0] addr,
  input wire logic [cts_pkg::RES_W-1:0] wdata,
  output logic [cts_pkg::RES_W-1:0] rdata
);
  logic [RES_W-1:0] mem [RAM_WORDS];

  // Read returns the old word on a write, so baselines are never read mid-update.
  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // cts_comp_ram

// ---- logic/cts_spi_link.sv ----
`timescale 1ns/1ps
// Serial read port, clocked by the host serial clock.
module cts_spi_link
  import cts_pkg::*;
(
  input wire logic sclk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  output logic req_tgl,
  output logic [7:0] req_addr,
  input wire logic ack_tgl,
  input wire logic [cts_pkg::RES_W-1:0] rd_data
);
  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] rx;
    logic [7:0] addr;
    logic req;
    logic [2:0] ack_s;
    logic ack_seen;
    logic [RES_W-1:0] tx;
  } cts_link_t;

  cts_link_t r;
  cts_link_t n;
  logic sdo_r;

  // Frames are a fixed 32 clocks; the counter wraps so the next frame starts clean.
  always_comb begin
    n = r;
    n.ack_s = {r.ack_s[1:0], ack_tgl};
    if (r.ack_s[1] == r.ack_s[2]) begin
      n.ack_seen = r.ack_s[2];
    end
    if (!cs_n) begin
      n.cnt = r.cnt + 5'h01;
      n.rx = {r.rx[6:0], sdi};
      if (r.cnt == BIT_ADDR_LAST) begin
        n.addr = {r.rx[6:0], sdi};
        n.req = ~r.req;
      end
      if (r.cnt == BIT_LOAD) begin
        n.tx = (r.ack_seen == r.req) ? rd_data : '0;
      end else if (r.cnt >= BIT_DATA_FIRST) begin
        n.tx = {r.tx[RES_W-2:0], 1'b0};
      end
    end
  end

  // Host serial clock is the only clock here.
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Data leaves on the falling edge so the host samples it on the next rise.
  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      sdo_r <= 1'b0;
    end else begin
      sdo_r <= r.tx[RES_W-1];
    end
  end

  assign sdo = sdo_r;
  assign sdo_oe_n = cs_n;
  assign req_tgl = r.req;
  assign req_addr = r.addr;
endmodule // cts_spi_link

// ---- logic/cts_core.sv ----
`timescale 1ns/1ps
// Function
// - Route any of 14 sensor inputs through the switch matrix to one converter.
// - Each conversion yields a 16-bit result kept in on-chip result registers.
// - A sequencer picks which inputs convert and in what order.
// - Per-sensor averaging, offset and gain come from host settings.
// - Compensation data lives in a 528-word internal memory.
// - Baselines track drift continuously and automatically without the host.
// - Button and eight-direction decisions are made entirely on chip.
// - Full power and low power auto wake-up modes are host selectable.
// - Interrupt asserts when new results are written.
// - Interrupt asserts when a sensor activation is detected.
// - Interrupt is open-drain, pulls only low, polarity is programmable.
// - Mode 00 full power, 10 low power, 01 or 11 shutdown; default 00.
// - Low power idle converts each 200 to 800 ms; touched, every 36 ms.
// - Decimation field 00 selects ratio 256, 01 selects 128.
module cts_core
  import cts_pkg::*;
#(
  parameter int TOUCH_PERIOD_CYCLES = cts_pkg::TOUCH_PERIOD_CYC,
  parameter int IDLE_STEP_CYCLES = cts_pkg::IDLE_STEP_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  output logic int_out,
  output logic int_oe_n,
  input wire logic int_active_high,
  input wire logic slave_addr_bit0_pin,
  input wire logic slave_addr_bit1_pin,
  output logic [1:0] i2c_addr_low,
  input wire logic [1:0] power_mode,
  input wire logic [1:0] decim_sel,
  input wire logic [1:0] idle_convert_interval,
  input wire logic [cts_pkg::N_SENSE-1:0] stage_enable,
  input wire logic [cts_pkg::N_SENSE-1:0][cts_pkg::AVG_W-1:0] sensor_avg,
  input wire logic [cts_pkg::N_SENSE-1:0][cts_pkg::RES_W-1:0] sensor_offset,
  input wire logic [cts_pkg::N_SENSE-1:0][cts_pkg::GAIN_W-1:0] sensor_gain,
  input wire logic [cts_pkg::RES_W-1:0] touch_threshold,
  output logic [cts_pkg::N_SENSE-1:0] sense_route,
  output logic conv_start,
  output logic [8:0] conv_osr,
  input wire logic conv_done,
  input wire logic [cts_pkg::RES_W-1:0] conv_data,
  output logic [cts_pkg::N_SENSE-1:0] sensor_active,
  output logic dir_valid,
  output logic [2:0] dir_code,
  output logic low_power_state
);
  // All state of the core in one record: the sequencer, the per-stage filters and
  // results, the flags behind the interrupt, and the request side of the serial
  // port. One combinational block computes the next record, one register holds it.
  // Keeping it in one place makes the reset values easy to audit.
  typedef struct packed {
    cts_state_t st;
    logic [3:0] stage;
    logic [TIMER_W-1:0] timer;
    logic [RES_W-1:0] raw;
    logic [N_SENSE-1:0][RES_W-1:0] avg;
    logic [N_SENSE-1:0][RES_W-1:0] result;
    logic [N_SENSE-1:0] init;
    logic [N_SENSE-1:0] active;
    logic did_conv;
    logic touched_seq;
    logic touched;
    logic flag_new;
    logic flag_act;
    logic [N_SENSE-1:0] route;
    logic conv_start;
    logic [8:0] osr;
    logic [2:0] req_s;
    logic req_seen;
    logic ack;
    logic [RES_W-1:0] rd_data;
    logic [2:0][1:0] strap_s;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [1:0] strap;
    logic int_oe_n;
    logic dir_valid;
    logic [2:0] dir;
    logic low_power;
  } cts_core_t;

  cts_core_t r;
  cts_core_t n;

  // Link side wires.
  logic req_tgl;
  logic [7:0] req_addr;

  // Compensation memory port.
  logic ram_we;
  logic [RES_W-1:0] ram_rdata;

  // Per-stage arithmetic of the calc state.
  logic signed [RES_W:0] diff;
  logic [RES_W-1:0] step;
  logic [RES_W-1:0] new_avg;
  logic [RES_W-1:0] adj;
  logic [RES_W-1:0] res;
  logic [RES_W-1:0] base;
  logic [RES_W-1:0] delta;
  logic [RES_W-1:0] new_base;
  logic touch;
  logic req_evt;
  logic asserted;
  logic [TIMER_W-1:0] idle_wait;
  logic [3:0] sidx;

  // The serial port lives in the host clock domain.
  // Only a toggle each way, a settled address and a settled word cross between the two
  // domains, so no multi-bit value is ever caught while it moves.
  cts_spi_link u_link (
    .sclk(sclk),
    .resetn(resetn),
    .cs_n(cs_n),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe_n(sdo_oe_n),
    .req_tgl(req_tgl),
    .req_addr(req_addr),
    .ack_tgl(r.ack),
    .rd_data(r.rd_data)
  );

  // Baselines are kept one word per stage.
  cts_comp_ram u_ram (
    .clock(clock),
    .we(ram_we),
    .addr(RAM_AW'(r.stage)),
    .wdata(new_base),
    .rdata(ram_rdata)
  );

  // The stage counter runs one past the last sensor while a sequence closes; the
  // clamp keeps every array read below in range at that point.
  assign sidx = (r.stage > LAST_STAGE) ? LAST_STAGE : r.stage;

  // Averaging, offset, gain and drift tracking for the current stage.
  // The average is an IIR filter whose weight is a shift, so no divider is needed.
  always_comb begin
    diff = $signed({1'b0, r.raw}) - $signed({1'b0, r.avg[sidx]});
    step = RES_W'(diff >>> sensor_avg[sidx]);
    new_avg = r.init[sidx] ? (r.avg[sidx] + step) : r.raw;
    adj = new_avg - sensor_offset[sidx];
    res = adj << sensor_gain[sidx];
    base = r.init[sidx] ? ram_rdata : res;
    delta = (res > base) ? (res - base) : (base - res);
    touch = delta > touch_threshold;
    // An untouched sensor walks its baseline one code toward the reading.
    // A touched one is frozen, so a long press is never learned as the new baseline.
    if (touch) begin
      new_base = base;
    end else if (res > base) begin
      new_base = base + BASE_STEP;
    end else if (res < base) begin
      new_base = base - BASE_STEP;
    end else begin
      new_base = base;
    end
  end

  // Each conversion writes its baseline back; a touch simply writes the old word.
  assign ram_we = (r.st == ST_CALC);

  // Low power idle wait grows in steps of the base interval.
  // The field picks one to four steps, the only intervals the mode offers.
  assign idle_wait = TIMER_W'(IDLE_STEP_CYCLES * (int'(idle_convert_interval) + 1) - 1);

  // A request toggle counts once the second and third stages agree.
  // Waiting for agreement costs a cycle but rejects a stage caught mid-change.
  assign req_evt = (r.req_s[1] == r.req_s[2]) && (r.req_s[2] != r.req_seen);

  // Next state of the whole core.
  always_comb begin
    n = r;
    n.conv_start = 1'b0;

    // Strap pins are synchronised, then caught once after reset.
    // The short settle count lets the straps stand after reset before they are taken.
    n.strap_s = {r.strap_s[1:0], {slave_addr_bit1_pin, slave_addr_bit0_pin}};
    if (!r.strap_done) begin
      if (r.strap_cnt != 2'h3) begin
        n.strap_cnt = r.strap_cnt + 2'h1;
      end else if (r.strap_s[1] == r.strap_s[2]) begin
        n.strap = r.strap_s[2];
        n.strap_done = 1'b1;
      end
    end

    // Host reads: the word is staged in the same cycle as the acknowledge toggle.
    // Word and toggle change on the same edge, and the link only looks at the word
    // after it has seen the toggle, so the word is settled by then.
    // A status read clears the flags, but a flag set in the same cycle still wins.
    n.req_s = {r.req_s[1:0], req_tgl};
    if (req_evt) begin
      n.req_seen = r.req_s[2];
      n.ack = ~r.ack;
      if (req_addr <= RD_RESULT_LAST) begin
        n.rd_data = r.result[req_addr[3:0]];
      end else if (req_addr == RD_STATUS) begin
        n.rd_data = RES_W'({r.touched, r.flag_act, r.flag_new});
        n.flag_new = 1'b0;
        n.flag_act = 1'b0;
      end else if (req_addr == RD_ACTIVE) begin
        n.rd_data = RES_W'(r.active);
      end else if (req_addr == RD_SETUP) begin
        n.rd_data = RES_W'({r.strap, decim_sel, power_mode});
      end else begin
        n.rd_data = '0;
      end
    end

    // Oversampling ratio follows the decimation field.
    unique case (decim_sel)
      DEC_128: n.osr = OSR_128;
      default: n.osr = OSR_256;
    endcase

    // Conversion sequencer.
    // One conversion is outstanding at a time; stages run in ascending order and
    // disabled stages cost one cycle each.
    unique case (r.st)
      ST_IDLE: begin
        n.route = '0;
        // Shutdown is honoured only here, so a running sequence always completes.
        if (power_mode[PM_SHUTDOWN_BIT]) begin
          n.timer = '0;
        end else if (r.timer != '0) begin
          n.timer = r.timer - TIMER_W'(1);
        end else begin
          n.stage = FIRST_STAGE;
          n.did_conv = 1'b0;
          n.touched_seq = 1'b0;
          n.st = ST_SEL;
        end
      end
      ST_SEL: begin
        if (r.stage > LAST_STAGE) begin
          // Sequence finished: flag new data and pick the wait before the next.
          // Built on the cleared value so a status read in this cycle is not undone.
          n.flag_new = n.flag_new | r.did_conv;
          n.touched = r.touched_seq;
          if (power_mode == PM_LOW) begin
            n.timer = r.touched_seq ? TIMER_W'(TOUCH_PERIOD_CYCLES - 1) : idle_wait;
          end else begin
            n.timer = '0;
          end
          n.st = ST_IDLE;
        end else if (stage_enable[r.stage]) begin
          n.st = ST_START;
        end else begin
          n.stage = r.stage + STAGE_STEP;
        end
      end
      ST_START: begin
        n.route = N_SENSE'(1) << r.stage;
        n.conv_start = 1'b1;
        n.st = ST_WAIT;
      end
      ST_WAIT: begin
        // The memory read of this stage's baseline runs while converting.
        // A late converter simply stretches this state; there is no timeout.
        if (conv_done) begin
          n.raw = conv_data;
          n.route = '0;
          n.st = ST_CALC;
        end
      end
      ST_CALC: begin
        // Activation is flagged only on a fresh touch, not for every touched sequence.
        n.avg[r.stage] = new_avg;
        n.result[r.stage] = res;
        n.init[r.stage] = 1'b1;
        n.active[r.stage] = touch;
        if (touch && !r.active[r.stage]) begin
          n.flag_act = 1'b1;
        end
        n.touched_seq = r.touched_seq | touch;
        n.did_conv = 1'b1;
        n.stage = r.stage + STAGE_STEP;
        n.st = ST_SEL;
      end
    endcase

    // Eight-way pad: lowest active sensor of the ring names the direction.
    // Sensors past the eighth are plain buttons and never name a direction.
    // Two neighbours touched at once resolve to the lower one.
    n.dir_valid = 1'b0;
    n.dir = '0;
    for (int i = DIR_COUNT - 1; i >= 0; i--) begin
      if (n.active[i]) begin
        n.dir_valid = 1'b1;
        n.dir = 3'(i);
      end
    end

    // Reduced power once idle in low power mode with nothing touched.
    n.low_power = (power_mode == PM_LOW) && (n.st == ST_IDLE) && !n.touched;

    // Open-drain: enable low pulls the pin low, released otherwise.
    // The pin is never driven high; the external pull-up makes the high level.
    // Taking the next-state flags saves a cycle of interrupt delay.
    asserted = n.flag_new | n.flag_act;
    n.int_oe_n = ~(asserted ^ int_active_high);
  end

  // Single register stage for the whole core; flags and state clear on reset.
  // The interrupt enable resets released, so the pin stays high through reset whatever the polarity.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.int_oe_n <= 1'b1;
      r.osr <= OSR_256;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the register stage.
  // No output is decoded from state, so none can glitch between edges.
  assign int_out = 1'b0;
  assign int_oe_n = r.int_oe_n;
  assign i2c_addr_low = r.strap;
  assign sense_route = r.route;
  assign conv_start = r.conv_start;
  assign conv_osr = r.osr;
  assign sensor_active = r.active;
  assign dir_valid = r.dir_valid;
  assign dir_code = r.dir;
  assign low_power_state = r.low_power;
endmodule // cts_core

// ---- bench/cts_assertions.sv ----
`timescale 1ns/1ps
// Watches the core's pins and ties each output back to its cause.
module cts_chk
  import cts_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sdo_oe_n,
  input wire logic int_out,
  input wire logic [1:0] power_mode,
  input wire logic [1:0] decim_sel,
  input wire logic [cts_pkg::N_SENSE-1:0] sense_route,
  input wire logic conv_start,
  input wire logic [8:0] conv_osr,
  input wire logic conv_done,
  input wire logic [cts_pkg::N_SENSE-1:0] sensor_active,
  input wire logic dir_valid,
  input wire logic [2:0] dir_code,
  input wire logic low_power_state
);
  logic [8:0] sd_cnt_r;
  logic [8:0] sd_cnt_nxt;

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  // Lowest active sensor among the first eight.
  function automatic logic [2:0] low8(input logic [7:0] a);
    low8 = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (a[i]) begin
        low8 = 3'(i);
      end
    end
  endfunction

  // Shutdown only bites after the running sequence, so count well past one.
  always_comb begin
    sd_cnt_nxt = 9'h000;
    if (power_mode[PM_SHUTDOWN_BIT]) begin
      sd_cnt_nxt = (sd_cnt_r == 9'h1FF) ? sd_cnt_r : sd_cnt_r + 9'h001;
    end
  end

  // Saturating counter of cycles spent with shutdown requested.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sd_cnt_r <= 9'h000;
    end else begin
      sd_cnt_r <= sd_cnt_nxt;
    end
  end

  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  chk_route_onehot: assert property (conv_start |-> $onehot(sense_route))
    else $error("route not one-hot at start");
  chk_route_hold: assert property ((sense_route != '0) && !conv_done |=> sense_route == $past(sense_route))
    else $error("route moved during conversion");
  chk_osr_select: assert property (conv_start |-> conv_osr == ((decim_sel == DEC_128) ? OSR_128 : OSR_256))
    else $error("ratio does not match field");
  chk_int_pull_only: assert property (int_out == 1'b0)
    else $error("interrupt driven high");
  chk_sdo_enable: assert property (sdo_oe_n == cs_n)
    else $error("data out enable off select");
  chk_shutdown_quiet: assert property (sd_cnt_r == 9'h1FF |-> !conv_start)
    else $error("conversion in shutdown");
  chk_dir_valid: assert property ($stable(sensor_active)[*3] |-> dir_valid == (|sensor_active[7:0]))
    else $error("direction valid wrong");
  chk_dir_code: assert property (dir_valid && $stable(sensor_active) |-> dir_code == low8(sensor_active[7:0]))
    else $error("direction code wrong");
  chk_lp_state: assert property ((power_mode != PM_LOW)[*2] |=> !low_power_state)
    else $error("low power state outside mode");

  cover property (conv_done);
  cover property ($rose(dir_valid));
  cover property (conv_start && power_mode == PM_LOW);
endmodule // cts_chk

// ---- bench/cts_host.sv ----
`timescale 1ns/1ps
// Host side of the serial port: owns the serial clock and frames reads.
module cts_host (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  output logic rd_stb,
  output logic [15:0] rd_word
);
  logic sdo_w;

  // The data line floats to its pull-up once the core lets go.
  assign sdo_w = sdo_oe_n ? 1'b1 : sdo;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    rd_stb = 1'b0;
    rd_word = 16'h0000;
  end

  // One 32-bit frame; the clock stands low between frames.
  task automatic rd(input logic [7:0] a);
    #7 cs_n = 1'b0;
    for (int i = 0; i < 32; i++) begin
      sdi = (i < 8) ? a[7 - i] : ~sdi;
      #32 sclk = 1'b1;
      if (i >= 16) begin
        rd_word = {rd_word[14:0], sdo_w};
      end
      #32 sclk = 1'b0;
    end
    #20 cs_n = 1'b1;
    sdi = ~sdi;
    rd_stb = 1'b1;
    #10 rd_stb = 1'b0;
  endtask
endmodule // cts_host

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  import cts_pkg::*;
  localparam int IDLE = 100;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic int_active_high = 1'b0;
  logic sclk, cs_n, sdi, sdo, sdo_oe_n, int_out, int_oe_n;
  logic [1:0] strap, power_mode, decim_sel, ivl, addr_low;
  logic [N_SENSE-1:0] en, route, active;
  logic [N_SENSE-1:0][AVG_W-1:0] avg = '0;
  logic [N_SENSE-1:0][RES_W-1:0] off;
  logic [N_SENSE-1:0][GAIN_W-1:0] gain;
  logic [15:0] thr, conv_data, rd_word;
  logic [15:0] cdat [N_SENSE];
  logic [8:0] osr;
  logic [2:0] dir_code;
  logic conv_start, conv_done, dir_valid, lps, rd_stb;
  logic [23:0] expq [$];
  int seed = 64292;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int k = 0;
  int n;

  cts_core #(.TOUCH_PERIOD_CYCLES(200), .IDLE_STEP_CYCLES(IDLE)) DUT (
    .clock(clock), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n), .int_out(int_out), .int_oe_n(int_oe_n),
    .int_active_high(int_active_high), .slave_addr_bit0_pin(strap[0]),
    .slave_addr_bit1_pin(strap[1]), .i2c_addr_low(addr_low), .power_mode(power_mode),
    .decim_sel(decim_sel), .idle_convert_interval(ivl), .stage_enable(en),
    .sensor_avg(avg), .sensor_offset(off), .sensor_gain(gain), .touch_threshold(thr),
    .sense_route(route), .conv_start(conv_start), .conv_osr(osr), .conv_done(conv_done),
    .conv_data(conv_data), .sensor_active(active), .dir_valid(dir_valid),
    .dir_code(dir_code), .low_power_state(lps)
  );

  cts_host u_host (
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .rd_stb(rd_stb), .rd_word(rd_word)
  );

  always #2.5 clock = ~clock;

  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Notes the expected word, then lets the host run the frame.
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expq.push_back({a, e});
    u_host.rd(a);
    @(negedge clock);
  endtask

  // Full power for a while, then a shutdown code long enough to go quiet.
  task automatic run(input logic [1:0] sd);
    power_mode = PM_FULL;
    repeat (600) @(negedge clock);
    power_mode = sd;
    repeat (600) @(negedge clock);
  endtask

  // Scaled result the core should hold for a stage.
  function automatic logic [15:0] res(input int i);
    res = (cdat[i] - off[i]) << gain[i];
  endfunction

  // Each finished frame answers the oldest outstanding read.
  always @(posedge rd_stb) begin
    logic [23:0] x;
    x = expq.pop_front();
    check($sformatf("reg %h", x[23:16]), rd_word, x[15:0]);
  end

  // Converter stand-in; the data bus churns while no result is offered.
  always @(negedge clock) begin
    conv_done = 1'b0;
    conv_data = $random(seed);
    if (conv_start) begin
      for (int i = 0; i < N_SENSE; i++) begin
        if (route[i]) begin
          k = i;
        end
      end
      repeat (3) @(negedge clock);
      conv_data = cdat[k];
      conv_done = 1'b1;
    end
  end

  // A hang anywhere ends the run as a failure.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    strap = $random(seed);
    power_mode = 2'h1;
    decim_sel = DEC_128;
    ivl = $random(seed);
    en = $random(seed);
    en[3] = 1'b1;
    en[5] = 1'b0;
    thr = 16'h0800;
    conv_done = 1'b0;
    conv_data = 16'h0000;
    for (int i = 0; i < N_SENSE; i++) begin
      cdat[i] = $random(seed);
      off[i] = $random(seed);
      gain[i] = $random(seed);
    end
    gain[3] = 2'h0;
    repeat (16) @(negedge clock);
    resetn = 1'b1;
    repeat (8) @(negedge clock);
    check("strap", 16'(addr_low), 16'(strap));
    check("int", 16'(int_oe_n), 16'h0001);
    rd(RD_SETUP, {10'h000, strap, 4'h5});
    rd(8'h20, 16'h0000);
    rd(RD_STATUS, 16'h0000);
    run(2'h3);
    check("int", 16'(int_oe_n), 16'h0000);
    for (int i = 0; i < N_SENSE; i++) begin
      rd(8'(i), en[i] ? res(i) : 16'h0000);
    end
    rd(RD_STATUS, 16'h0001);
    rd(RD_STATUS, 16'h0000);
    check("int", 16'(int_oe_n), 16'h0001);
    decim_sel = DEC_256;
    cdat[3] = cdat[3] + 16'h2000;
    run(2'h1);
    check("dir", 16'({dir_valid, dir_code}), 16'h000B);
    rd(RD_ACTIVE, 16'h0008);
    int_active_high = 1'b1;
    repeat (4) @(negedge clock);
    check("int", 16'(int_oe_n), 16'h0001);
    rd(RD_STATUS, 16'h0007);
    check("int", 16'(int_oe_n), 16'h0000);
    // Untouched low power: the next sequence waits the programmed interval.
    cdat[3] = cdat[3] - 16'h2000;
    decim_sel = 2'h2;
    power_mode = PM_LOW;
    n = 0;
    while (lps !== 1'b1 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    n = 0;
    check("lps", 16'(lps), 16'h0001);
    while (conv_start !== 1'b1 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    check("gap", 16'(n >= (ivl + 1) * IDLE - 8 && n <= (ivl + 1) * IDLE + 8), 16'h0001);
    tally_and_finish();
  end
endmodule // tb

bind cts_core cts_chk u_chk (
  .clock(clock), .resetn(resetn), .cs_n(cs_n), .sdo_oe_n(sdo_oe_n), .int_out(int_out),
  .power_mode(power_mode), .decim_sel(decim_sel), .sense_route(sense_route),
  .conv_start(conv_start), .conv_osr(conv_osr), .conv_done(conv_done),
  .sensor_active(sensor_active), .dir_valid(dir_valid), .dir_code(dir_code),
  .low_power_state(low_power_state)
);
